/* File: common/soar_regs.vh */
// soar_regs.vh: byte addresses, field positions, reset values and codes
// for the impact recorder output and alarm registers.
// assumes: included by the rtl files of the soar block only.
`ifndef SOAR_REGS_VH
`define SOAR_REGS_VH

// byte addresses (lower byte of each 16-bit register)
`define SOAR_ADDR_SUPPLY 7'h02
`define SOAR_ADDR_ACC_X 7'h04
`define SOAR_ADDR_ACC_Y 7'h06
`define SOAR_ADDR_ACC_Z 7'h08
`define SOAR_ADDR_AUX 7'h0A
`define SOAR_ADDR_TEMP 7'h0C
`define SOAR_ADDR_PEAK_X 7'h0E
`define SOAR_ADDR_PEAK_Y 7'h10
`define SOAR_ADDR_PEAK_Z 7'h12
`define SOAR_ADDR_PEAK_XYZ 7'h14
`define SOAR_ADDR_DIAG 7'h1A
`define SOAR_ADDR_THR1 7'h38
`define SOAR_ADDR_THR2 7'h3A
`define SOAR_ADDR_ALARM_CONTROL_WORD 7'h3C
`define SOAR_ADDR_MISC 7'h46
`define SOAR_ADDR_GLOB 7'h4A

// output word flags
`define SOAR_BIT_NEW_DATA 15
`define SOAR_BIT_ERR_ACT 14

// threshold fields
`define SOAR_BIT_THR_DIR 15
`define SOAR_THR_MAG_W 14
`define SOAR_THR_MASK 16'hBFFF

// alarm control fields
`define SOAR_ALM2_SRC_LSB 12
`define SOAR_ALM1_SRC_LSB 8
`define SOAR_BIT_ALM1_CAPT 4
`define SOAR_BIT_IND_EN 2
`define SOAR_BIT_IND_POL 1
`define SOAR_BIT_IND_PIN 0
`define SOAR_ALARM_CONTROL_WORD_MASK 16'hFF37

// misc control fields
`define SOAR_BIT_PEAK_EN 14
`define SOAR_BIT_XYZ_EN 15
`define SOAR_BIT_DRDY_EN 2

// global command fields
`define SOAR_BIT_PEAK_CLR 5

// reset values
`define SOAR_RST_THR 16'h9000
`define SOAR_RST_ALARM_CONTROL_WORD 16'h0000
`define SOAR_RST_MISC 16'h0006

// alarm source codes
`define SOAR_SRC_OFF 4'h0
`define SOAR_SRC_SUPPLY 4'h1
`define SOAR_SRC_X 4'h2
`define SOAR_SRC_Y 4'h3
`define SOAR_SRC_Z 4'h4
`define SOAR_SRC_AUX 4'h5
`define SOAR_SRC_TEMP 4'h6
`define SOAR_SRC_XYZ 4'h7
`define SOAR_SRC_EXT 4'h8

// serial frame and sum-of-squares scaling
`define SOAR_FRAME_BITS 16
`define SOAR_XYZ_SHIFT 8

`endif

/* File: rtl/soar_spi_port.v */
// soar_spi_port: 16-bit serial slave, mode 3 (idle high, sample on rise).
// assumes: sclk at most clk/8; pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "soar_regs.vh"

module soar_spi_port (
  input wire clk, // system clock
  input wire rst_n, // async reset, active low
  input wire sclk, // serial clock pin
  input wire cs_n, // chip select pin, active low
  input wire din, // serial data in pin
  input wire [15:0] tx_word, // word to shift out in the next frame
  output reg dout, // serial data out
  output reg [15:0] rx_word, // last complete received frame
  output reg rx_done // one-cycle pulse when a frame completes
);

  reg [2:0] sync1;
  reg [2:0] sync2;
  reg sclk_d;
  reg cs_d;
  reg [15:0] sh_rx;
  reg [15:0] sh_tx;
  reg [4:0] cnt;

  wire sc = sync2[2];
  wire cs = sync2[1];
  wire di = sync2[0];
  wire rise = sc & ~sclk_d;
  wire fall = ~sc & sclk_d;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 3'h6;
      sync2 <= 3'h6;
      sclk_d <= 1'b1;
      cs_d <= 1'b1;
      sh_rx <= 16'h0000;
      sh_tx <= 16'h0000;
      cnt <= 5'h00;
      dout <= 1'b0;
      rx_word <= 16'h0000;
      rx_done <= 1'b0;
    end else begin
      sync1 <= {sclk, cs_n, din};
      sync2 <= sync1;
      sclk_d <= sc;
      cs_d <= cs;
      rx_done <= 1'b0;
      if (cs) begin
        dout <= 1'b0;
        cnt <= 5'h00;
      end else if (cs_d) begin
        sh_tx <= tx_word;
        cnt <= 5'h00;
      end else begin
        if (fall) begin
          dout <= sh_tx[15];
          sh_tx <= {sh_tx[14:0], 1'b0};
        end
        if (rise) begin
          sh_rx <= {sh_rx[14:0], di};
          cnt <= cnt + 5'h01;
          if (cnt == `SOAR_FRAME_BITS - 1) begin
            rx_word <= {sh_rx[14:0], di};
            rx_done <= 1'b1;
          end
        end
      end
    end
  end

endmodule // soar_spi_port

/* File: rtl/soar_top.v */
// soar_top: output data words, peak tracking, alarms, capture memory.
// assumes: sample_* come from the sampler on clk, valid with sample_strobe;
// serial pins and ext_trig are asynchronous.
`timescale 1ns/1ps
`include "soar_regs.vh"

// Overview of operation
// - reading an output word clears its new-data flag to zero.
// - the next internal sample into a word sets its new-data flag again.
// - in data-ready mode every new-data flag reads as one.
// - every output word shows error-active when any diagnostic flag is set.
// - acceleration and per-axis peak words hold 10-bit twos-complement values.
// - supply word holds 10-bit unsigned value, zero means 0 V.
// - temperature word holds 10-bit unsigned value as delivered by sampler.
// - misc bit 14 makes per-axis peak words track largest acceleration.
// - misc bit 15 enables a 12-bit sum-of-squares peak word.
// - writing one to command bit 5 clears all peak words.
// - each 16-bit register spans two bytes, high byte at address plus one.
// - a capture memory of three 8192-entry 8-bit arrays records samples.
// - alarm-two source field in bits 15:12 picks the compared word.
// - bits 11:8 pick the alarm-one source with the same codes.
// - control bits 5 and 4 let alarm two and one start a capture.
// - control bits 2,1,0 give indicator enable, polarity and pin choice.
// - threshold bit 15 picks above (1) or below (0) comparison.
// - threshold bits 13:0 hold an unsigned magnitude in source scaling.
// - a read takes two 16-bit frames; data returns in the second.
module soar_top #(
  parameter CAPT_DEPTH = 8192, // entries per axis array
  parameter CAPT_AW = 13, // capture address width
  parameter CAPT_LEN = 256 // samples stored per triggered capture
) (
  input wire clk, // system clock, 50 MHz
  input wire rst_n, // async reset, active low
  input wire spi_sclk, // serial clock pin
  input wire spi_cs_n, // chip select pin, active low
  input wire spi_din, // serial data in pin
  output wire spi_dout, // serial data out pin
  input wire sample_strobe, // one-cycle pulse, new sample set valid
  input wire [9:0] sample_supply, // supply code
  input wire [9:0] sample_x, // x acceleration, twos complement
  input wire [9:0] sample_y, // y acceleration, twos complement
  input wire [9:0] sample_z, // z acceleration, twos complement
  input wire [9:0] sample_aux, // auxiliary input code
  input wire [9:0] sample_temp, // temperature code
  input wire [15:0] diag_status, // diagnostic error flags
  input wire ext_trig, // external trigger pin, active high
  output reg digital_io_one_out, // first digital io level
  output reg digital_io_one_oe, // first digital io drive enable
  output reg digital_io_two_out, // second digital io level
  output reg digital_io_two_oe, // second digital io drive enable
  output reg capture_busy, // capture in progress
  input wire [CAPT_AW-1:0] capt_rd_addr, // capture memory read address
  output reg [23:0] capt_rd_data // {z,y,x} from capture memory
);

  function [10:0] abs10;
    input [9:0] v;
    begin
      abs10 = v[9] ? (11'h000 - {v[9], v}) : {1'b0, v};
    end
  endfunction

  // serial port
  wire [15:0] rx_word;
  wire rx_done;
  reg [15:0] tx_word;

  soar_spi_port u_spi (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .din(spi_din),
    .tx_word(tx_word),
    .dout(spi_dout),
    .rx_word(rx_word),
    .rx_done(rx_done)
  );

  wire is_wr = rx_word[15];
  wire [6:0] addr = rx_word[14:8];
  wire [6:0] base = {addr[6:1], 1'b0};
  wire [7:0] wdata = rx_word[7:0];
  wire rd_cmd = rx_done & ~is_wr;
  wire wr_cmd = rx_done & is_wr;

  // data words and configuration
  reg [9:0] supply_voltage_word;
  reg [9:0] accel_x_word;
  reg [9:0] accel_y_word;
  reg [9:0] accel_z_word;
  reg [9:0] auxiliary_voltage_word;
  reg [9:0] temperature_word;
  reg [9:0] peak_x_word;
  reg [9:0] peak_y_word;
  reg [9:0] peak_z_word;
  reg [11:0] sum_squares_peak_word;
  reg [15:0] alarm_one_threshold;
  reg [15:0] alarm_two_threshold;
  reg [15:0] alarm_control_word;
  reg [15:0] misc_control_word;
  reg [15:0] diag_q;
  reg sample_d;
  reg [1:0] ext_sync;

  wire peak_en = misc_control_word[`SOAR_BIT_PEAK_EN];
  wire xyz_en = misc_control_word[`SOAR_BIT_XYZ_EN];
  wire drdy_mode = misc_control_word[`SOAR_BIT_DRDY_EN];
  wire peak_clr = wr_cmd & (addr == `SOAR_ADDR_GLOB) & wdata[`SOAR_BIT_PEAK_CLR];
  wire ext_s = ext_sync[1];

  // sum of squares, scaled so one step is 256 input squared steps
  wire [10:0] ax = abs10(sample_x);
  wire [10:0] ay = abs10(sample_y);
  wire [10:0] az = abs10(sample_z);
  wire [21:0] sq_x = ax * ax;
  wire [21:0] sq_y = ay * ay;
  wire [21:0] sq_z = az * az;
  wire [21:0] sq_sum = sq_x + sq_y + sq_z;
  wire [11:0] sq_scaled = sq_sum[`SOAR_XYZ_SHIFT+11:`SOAR_XYZ_SHIFT];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_voltage_word <= 10'h000;
      accel_x_word <= 10'h000;
      accel_y_word <= 10'h000;
      accel_z_word <= 10'h000;
      auxiliary_voltage_word <= 10'h000;
      temperature_word <= 10'h000;
      diag_q <= 16'h0000;
      sample_d <= 1'b0;
      ext_sync <= 2'h0;
    end else begin
      diag_q <= diag_status;
      sample_d <= sample_strobe;
      ext_sync <= {ext_sync[0], ext_trig};
      if (sample_strobe) begin
        supply_voltage_word <= sample_supply;
        accel_x_word <= sample_x;
        accel_y_word <= sample_y;
        accel_z_word <= sample_z;
        auxiliary_voltage_word <= sample_aux;
        temperature_word <= sample_temp;
      end
    end
  end

  // peak words
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_x_word <= 10'h000;
      peak_y_word <= 10'h000;
      peak_z_word <= 10'h000;
      sum_squares_peak_word <= 12'h000;
    end else if (peak_clr) begin
      peak_x_word <= 10'h000;
      peak_y_word <= 10'h000;
      peak_z_word <= 10'h000;
      sum_squares_peak_word <= 12'h000;
    end else if (sample_strobe) begin
      if (peak_en && ax > abs10(peak_x_word))
        peak_x_word <= sample_x;
      if (peak_en && ay > abs10(peak_y_word))
        peak_y_word <= sample_y;
      if (peak_en && az > abs10(peak_z_word))
        peak_z_word <= sample_z;
      if (xyz_en && sq_scaled > sum_squares_peak_word)
        sum_squares_peak_word <= sq_scaled;
    end
  end

  // new-data flags, bit index is the word address over two
  wire [10:1] upd;
  wire [10:1] nd;
  assign upd[6:1] = {6{sample_strobe}};
  assign upd[9:7] = {3{sample_strobe & peak_en}};
  assign upd[10] = sample_strobe & xyz_en;

  genvar gi;
  generate
    for (gi = 1; gi <= 10; gi = gi + 1) begin : g_nd
      reg flag;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          flag <= 1'b0;
        else if (upd[gi])
          flag <= 1'b1;
        else if (rd_cmd && addr[6:1] == gi)
          flag <= 1'b0;
      end
      assign nd[gi] = flag;
    end
  endgenerate

  // read answer for the next frame
  wire ea = |diag_q;
  reg [15:0] rd_val;
  reg [15:0] rd_word;
  reg nd_sel;

  always @* begin
    rd_val = 16'h0000;
    nd_sel = 1'b0;
    case (base)
      `SOAR_ADDR_SUPPLY: begin
        rd_val = {6'h00, supply_voltage_word};
        nd_sel = nd[1];
      end
      `SOAR_ADDR_ACC_X: begin
        rd_val = {6'h00, accel_x_word};
        nd_sel = nd[2];
      end
      `SOAR_ADDR_ACC_Y: begin
        rd_val = {6'h00, accel_y_word};
        nd_sel = nd[3];
      end
      `SOAR_ADDR_ACC_Z: begin
        rd_val = {6'h00, accel_z_word};
        nd_sel = nd[4];
      end
      `SOAR_ADDR_AUX: begin
        rd_val = {6'h00, auxiliary_voltage_word};
        nd_sel = nd[5];
      end
      `SOAR_ADDR_TEMP: begin
        rd_val = {6'h00, temperature_word};
        nd_sel = nd[6];
      end
      `SOAR_ADDR_PEAK_X: begin
        rd_val = {6'h00, peak_x_word};
        nd_sel = nd[7];
      end
      `SOAR_ADDR_PEAK_Y: begin
        rd_val = {6'h00, peak_y_word};
        nd_sel = nd[8];
      end
      `SOAR_ADDR_PEAK_Z: begin
        rd_val = {6'h00, peak_z_word};
        nd_sel = nd[9];
      end
      `SOAR_ADDR_PEAK_XYZ: begin
        rd_val = {4'h0, sum_squares_peak_word};
        nd_sel = nd[10];
      end
      `SOAR_ADDR_DIAG: rd_val = diag_q;
      `SOAR_ADDR_THR1: rd_val = alarm_one_threshold & `SOAR_THR_MASK;
      `SOAR_ADDR_THR2: rd_val = alarm_two_threshold & `SOAR_THR_MASK;
      `SOAR_ADDR_ALARM_CONTROL_WORD: rd_val = alarm_control_word & `SOAR_ALARM_CONTROL_WORD_MASK;
      `SOAR_ADDR_MISC: rd_val = misc_control_word;
      default: rd_val = 16'h0000;
    endcase
    rd_word = rd_val;
    if (base >= `SOAR_ADDR_SUPPLY && base <= `SOAR_ADDR_PEAK_XYZ) begin
      rd_word[`SOAR_BIT_NEW_DATA] = nd_sel | drdy_mode;
      rd_word[`SOAR_BIT_ERR_ACT] = ea;
    end
  end

  // register writes, one byte per frame
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word <= 16'h0000;
      alarm_one_threshold <= `SOAR_RST_THR;
      alarm_two_threshold <= `SOAR_RST_THR;
      alarm_control_word <= `SOAR_RST_ALARM_CONTROL_WORD;
      misc_control_word <= `SOAR_RST_MISC;
    end else if (rx_done) begin
      tx_word <= is_wr ? 16'h0000 : rd_word;
      if (is_wr) begin
        case (base)
          `SOAR_ADDR_THR1:
            if (addr[0])
              alarm_one_threshold[15:8] <= wdata;
            else
              alarm_one_threshold[7:0] <= wdata;
          `SOAR_ADDR_THR2:
            if (addr[0])
              alarm_two_threshold[15:8] <= wdata;
            else
              alarm_two_threshold[7:0] <= wdata;
          `SOAR_ADDR_ALARM_CONTROL_WORD:
            if (addr[0])
              alarm_control_word[15:8] <= wdata;
            else
              alarm_control_word[7:0] <= wdata;
          `SOAR_ADDR_MISC:
            if (addr[0])
              misc_control_word[15:8] <= wdata;
            else
              misc_control_word[7:0] <= wdata;
          default: ;
        endcase
      end
    end
  end

  // alarms
  wire [1:0] alm_act;
  wire [1:0] alm_start;

  genvar ga;
  generate
    for (ga = 0; ga < 2; ga = ga + 1) begin : g_alm
      wire [3:0] sel = alarm_control_word[`SOAR_ALM1_SRC_LSB+4*ga +: 4];
      wire [15:0] thr = (ga == 0) ? alarm_one_threshold : alarm_two_threshold;
      wire [13:0] mag = thr[`SOAR_THR_MAG_W-1:0];
      reg [13:0] v;
      reg act;
      reg act_d;
      always @* begin
        case (sel)
          `SOAR_SRC_SUPPLY: v = {4'h0, supply_voltage_word};
          `SOAR_SRC_X: v = {3'h0, abs10(accel_x_word)};
          `SOAR_SRC_Y: v = {3'h0, abs10(accel_y_word)};
          `SOAR_SRC_Z: v = {3'h0, abs10(accel_z_word)};
          `SOAR_SRC_AUX: v = {4'h0, auxiliary_voltage_word};
          `SOAR_SRC_TEMP: v = {4'h0, temperature_word};
          `SOAR_SRC_XYZ: v = {2'h0, sum_squares_peak_word};
          default: v = 14'h0000;
        endcase
      end
      wire hit = thr[`SOAR_BIT_THR_DIR] ? (v > mag) : (v < mag);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          act <= 1'b0;
          act_d <= 1'b0;
        end else begin
          act_d <= act;
          if (sel == `SOAR_SRC_EXT)
            act <= ext_s;
          else if (sel == `SOAR_SRC_OFF || sel > `SOAR_SRC_EXT)
            act <= 1'b0;
          else if (sample_d)
            act <= hit;
        end
      end
      assign alm_act[ga] = act;
      assign alm_start[ga] = act & ~act_d &
        alarm_control_word[`SOAR_BIT_ALM1_CAPT+ga];
    end
  endgenerate

  // alarm indicator
  wire ind_on = |alm_act;
  wire ind_lvl = alarm_control_word[`SOAR_BIT_IND_POL] ? ind_on : ~ind_on;
  wire ind_en = alarm_control_word[`SOAR_BIT_IND_EN];
  wire ind_pin2 = alarm_control_word[`SOAR_BIT_IND_PIN];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digital_io_one_out <= 1'b0;
      digital_io_one_oe <= 1'b0;
      digital_io_two_out <= 1'b0;
      digital_io_two_oe <= 1'b0;
    end else begin
      digital_io_one_oe <= ind_en & ~ind_pin2;
      digital_io_two_oe <= ind_en & ind_pin2;
      digital_io_one_out <= ind_en & ~ind_pin2 & ind_lvl;
      digital_io_two_out <= ind_en & ind_pin2 & ind_lvl;
    end
  end

  // capture memory, 8 most significant bits of each axis
  reg [7:0] mem_x [0:CAPT_DEPTH-1];
  reg [7:0] mem_y [0:CAPT_DEPTH-1];
  reg [7:0] mem_z [0:CAPT_DEPTH-1];
  reg [CAPT_AW-1:0] wr_ptr;
  reg [CAPT_AW:0] wr_cnt;
  wire capt_wr = capture_busy & sample_d;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_busy <= 1'b0;
      wr_ptr <= {CAPT_AW{1'b0}};
      wr_cnt <= {(CAPT_AW+1){1'b0}};
    end else if (!capture_busy) begin
      wr_cnt <= {(CAPT_AW+1){1'b0}};
      if (|alm_start)
        capture_busy <= 1'b1;
    end else if (capt_wr) begin
      wr_ptr <= wr_ptr + 1'b1;
      wr_cnt <= wr_cnt + 1'b1;
      if (wr_cnt == CAPT_LEN - 1)
        capture_busy <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (capt_wr) begin
      mem_x[wr_ptr] <= accel_x_word[9:2];
      mem_y[wr_ptr] <= accel_y_word[9:2];
      mem_z[wr_ptr] <= accel_z_word[9:2];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      capt_rd_data <= 24'h000000;
    else
      capt_rd_data <= {mem_z[capt_rd_addr], mem_y[capt_rd_addr], mem_x[capt_rd_addr]};
  end

endmodule // soar_top

/* File: sim/soar_host.sv */
// soar_host: serial master model, 16-bit mode 3 frames.
// assumes: clk is the 50 MHz system clock; sclk runs at clk/10.
`timescale 1ns/1ps
module soar_host (
  input wire clk, // system clock
  output reg sclk, // serial clock, idles high
  output reg cs_n, // select, active low
  output reg din, // bits to device
  input wire dout // bits from device
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end
  // drive on the fall, take the reply on the rise
  task xfer(input [15:0] tx, output [15:0] rx);
    integer i;
    begin
      @(posedge clk) #2 cs_n = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        repeat (5) @(posedge clk);
        #2 sclk = 1'b0;
        din = tx[i];
        repeat (5) @(posedge clk);
        #2 sclk = 1'b1;
        rx[i] = dout;
      end
      repeat (5) @(posedge clk);
      #2 cs_n = 1'b1;
      din = ~din;
      repeat (8) @(posedge clk);
      #2;
    end
  endtask
endmodule // soar_host

/* File: sim/soar_monitor.sv */
// soar_monitor: port assertions for the output and alarm block.
// assumes: bound to soar_top; one clock domain.
`timescale 1ns/1ps
module soar_monitor #(
  parameter CAPT_AW = 13 // capture address width
) (
  input wire clk, // clock
  input wire rst_n, // reset, active low
  input wire spi_sclk, // serial clock
  input wire spi_cs_n, // select
  input wire spi_dout, // reply pin
  input wire sample_strobe, // new sample
  input wire ext_trig, // trigger pin
  input wire digital_io_one_out, // io one level
  input wire digital_io_one_oe, // io one enable
  input wire digital_io_two_out, // io two level
  input wire digital_io_two_oe, // io two enable
  input wire capture_busy, // capture running
  input wire [CAPT_AW-1:0] capt_rd_addr, // read address
  input wire [23:0] capt_rd_data // read data
);
  reg ext_q;
  reg [3:0] quiet;
  // cycles since the last event that may move an output
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
      quiet <= 4'hF;
    end else begin
      ext_q <= ext_trig;
      if (sample_strobe || !spi_cs_n || ext_trig != ext_q) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cs_idle;
    spi_cs_n [*6];
  endsequence
  sequence s_in_frame;
    !spi_cs_n && !$past(spi_cs_n, 6);
  endsequence
  property p_dout_idle;
    s_cs_idle |-> !spi_dout;
  endproperty
  property p_dout_edge;
    s_in_frame ##0 $changed(spi_dout) |-> !spi_sclk;
  endproperty
  property p_oe1;
    !digital_io_one_oe |-> !digital_io_one_out;
  endproperty
  property p_oe2;
    !digital_io_two_oe |-> !digital_io_two_out;
  endproperty
  property p_excl;
    !(digital_io_one_oe && digital_io_two_oe);
  endproperty
  property p_dio_cause;
    $changed({digital_io_one_out, digital_io_one_oe, digital_io_two_out, digital_io_two_oe}) |-> quiet < 4'hC;
  endproperty
  property p_busy_cause;
    $changed(capture_busy) |-> quiet < 4'hC;
  endproperty
  property p_capt_hold;
    $changed(capt_rd_data) |-> quiet < 4'h4 || $past(capt_rd_addr) != $past(capt_rd_addr, 2);
  endproperty
  a_dout_idle: assert property (p_dout_idle)
    else $error("reply pin not low while deselected");
  a_dout_edge: assert property (p_dout_edge)
    else $error("reply pin moved while serial clock high");
  a_oe1: assert property (p_oe1)
    else $error("io one level high while not driven");
  a_oe2: assert property (p_oe2)
    else $error("io two level high while not driven");
  a_excl: assert property (p_excl)
    else $error("both indicator pins driven");
  a_dio_cause: assert property (p_dio_cause)
    else $error("indicator moved with no sample or trigger");
  a_busy_cause: assert property (p_busy_cause)
    else $error("capture busy moved with no cause");
  a_capt_hold: assert property (p_capt_hold)
    else $error("capture data moved with no write or address change");
endmodule // soar_monitor
bind soar_top soar_monitor #(.CAPT_AW(CAPT_AW)) i_mon (.clk(clk), .rst_n(rst_n),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout),
  .sample_strobe(sample_strobe), .ext_trig(ext_trig), .digital_io_one_out(digital_io_one_out),
  .digital_io_one_oe(digital_io_one_oe), .digital_io_two_out(digital_io_two_out), .digital_io_two_oe(digital_io_two_oe),
  .capture_busy(capture_busy), .capt_rd_addr(capt_rd_addr), .capt_rd_data(capt_rd_data));

/* File: sim/tb.sv */
// tb: self-checking bench for soar_top over the serial port.
// assumes: soar_host drives the serial pins; capture length 4.
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg sample_strobe = 1'b0;
  reg [59:0] smp_v = 60'h0;
  reg [15:0] diag_status = 16'h0000;
  reg ext_trig = 1'b0;
  reg [12:0] capt_rd_addr = 13'h0000;
  wire spi_sclk, spi_cs_n, spi_din, spi_dout;
  wire digital_io_one_out, digital_io_one_oe, digital_io_two_out, digital_io_two_oe, capture_busy;
  wire [23:0] capt_rd_data;
  integer fails = 0;
  integer cmp_count = 0;
  integer s;
  reg [15:0] rx;
  always #10 clk = ~clk;
  soar_top #(.CAPT_LEN(4)) i_dut (.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .sample_strobe(sample_strobe), .sample_supply(smp_v[59:50]), .sample_x(smp_v[49:40]),
    .sample_y(smp_v[39:30]), .sample_z(smp_v[29:20]), .sample_aux(smp_v[19:10]),
    .sample_temp(smp_v[9:0]), .diag_status(diag_status), .ext_trig(ext_trig),
    .digital_io_one_out(digital_io_one_out), .digital_io_one_oe(digital_io_one_oe), .digital_io_two_out(digital_io_two_out), .digital_io_two_oe(digital_io_two_oe),
    .capture_busy(capture_busy), .capt_rd_addr(capt_rd_addr), .capt_rd_data(capt_rd_data));
  soar_host i_host (.clk(clk), .sclk(spi_sclk), .cs_n(spi_cs_n), .din(spi_din),
    .dout(spi_dout));
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #2;
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    i_host.xfer({1'b1, a, d}, rx);
  endtask
  task rd(input [6:0] a, input [15:0] m, input [15:0] e, input [63:0] nm);
    begin
      i_host.xfer({1'b0, a, 8'h00}, rx);
      i_host.xfer(16'h0000, rx);
      chk(rx & m, e, nm);
    end
  endtask
  // order of fields: supply, x, y, z, aux, temp
  task smp(input [59:0] v);
    begin
      @(posedge clk) #2 smp_v = v;
      sample_strobe = 1'b1;
      @(posedge clk) #2 sample_strobe = 1'b0;
      tick(6);
    end
  endtask
  function [59:0] one(input integer k, input [9:0] v);
    one = {50'h0, v} << ((6 - k) * 10);
  endfunction
  initial begin
    #1500000;
    fails = fails + 1;
    end_of_test;
  end
  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(6);
    rd(7'h38, 16'hFFFF, 16'h9000, "thr1");
    rd(7'h3B, 16'hFFFF, 16'h9000, "thr2");
    rd(7'h3C, 16'hFFFF, 16'h0000, "alarm_control_word");
    rd(7'h7E, 16'hFFFF, 16'h0000, "unmapped");
    wr(7'h46, 8'h02);
    smp({10'h2A4, 10'h3FF, 10'h137, 10'h2C9, 10'h155, 10'h133});
    rd(7'h04, 16'hFFFF, 16'h83FF, "acc_x");
    rd(7'h05, 16'hFFFF, 16'h03FF, "acc_x");
    rd(7'h06, 16'hFFFF, 16'h8137, "acc_y");
    rd(7'h08, 16'hFFFF, 16'h82C9, "acc_z");
    rd(7'h02, 16'hFFFF, 16'h82A4, "supply");
    rd(7'h0C, 16'hFFFF, 16'h8133, "temp");
    diag_status = 16'h0004;
    tick(4);
    rd(7'h04, 16'hFFFF, 16'h43FF, "acc_x");
    rd(7'h1A, 16'hFFFF, 16'h0004, "diag");
    diag_status = 16'h0000;
    smp(60'h0);
    rd(7'h04, 16'hFFFF, 16'h8000, "acc_x");
    wr(7'h46, 8'h06);
    rd(7'h04, 16'h8000, 16'h8000, "acc_x");
    wr(7'h47, 8'hC0);
    wr(7'h4A, 8'h20);
    smp(one(2, 10'h005));
    smp({10'h0, 10'h3EC, 10'h020, 10'h020, 20'h0});
    smp(one(2, 10'h003));
    rd(7'h0E, 16'h03FF, 16'h03EC, "peak_x");
    rd(7'h10, 16'h03FF, 16'h0020, "peak_y");
    rd(7'h14, 16'h0FFF, 16'h0009, "peak_xyz");
    wr(7'h4A, 8'h20);
    rd(7'h0E, 16'h03FF, 16'h0000, "peak_x");
    rd(7'h14, 16'h0FFF, 16'h0000, "peak_xyz");
    wr(7'h3B, 8'h80);
    wr(7'h3A, 8'h32);
    wr(7'h3C, 8'h07);
    for (s = 1; s <= 6; s = s + 1) begin
      wr(7'h3D, {s[3:0], 4'h0});
      smp(60'h0);
      chk(digital_io_two_out, 1'b0, "digital_io_two");
      smp(one(s, 10'h064));
      chk(digital_io_two_out, 1'b1, "digital_io_two");
    end
    // sum-of-squares source: peak is 39 here, 200 on x gives 156
    wr(7'h3D, 8'h70);
    smp(60'h0);
    chk(digital_io_two_out, 1'b0, "digital_io_two");
    smp(one(2, 10'h0C8));
    chk(digital_io_two_out, 1'b1, "digital_io_two");
    wr(7'h3D, 8'h60);
    chk(digital_io_two_oe, 1'b1, "digital_io_two_oe");
    chk(digital_io_one_oe, 1'b0, "digital_io_one_oe");
    wr(7'h3B, 8'h00);
    smp(one(6, 10'h064));
    chk(digital_io_two_out, 1'b0, "digital_io_two");
    smp(60'h0);
    chk(digital_io_two_out, 1'b1, "digital_io_two");
    wr(7'h3C, 8'h04);
    chk(digital_io_one_oe, 1'b1, "digital_io_one_oe");
    chk(digital_io_one_out, 1'b0, "digital_io_one");
    wr(7'h3D, 8'h00);
    smp(60'h0);
    chk(digital_io_one_out, 1'b1, "digital_io_one");
    wr(7'h3D, 8'h80);
    ext_trig = 1'b1;
    tick(8);
    chk(digital_io_one_out, 1'b0, "digital_io_one");
    ext_trig = 1'b0;
    tick(8);
    chk(digital_io_one_out, 1'b1, "digital_io_one");
    wr(7'h3D, 8'h06);
    wr(7'h39, 8'h80);
    wr(7'h38, 8'h32);
    smp(one(6, 10'h064));
    chk(digital_io_one_out, 1'b0, "digital_io_one");
    wr(7'h3C, 8'h14);
    smp(60'h0);
    smp(one(6, 10'h064));
    chk(capture_busy, 1'b1, "busy");
    capt_rd_addr = 13'h0001;
    for (s = 0; s < 5; s = s + 1) smp(one(2, 10'h0FC));
    chk(capture_busy, 1'b0, "busy");
    chk(capt_rd_data[15:0], 16'h003F, "capt_yx");
    chk(capt_rd_data[23:8], 16'h0000, "capt_zy");
    end_of_test;
  end
endmodule // tb
